// [lwx_pkg.sv]
// Package of constants and types for the latch-write, test and XOR execute block
package lwx_pkg;
    // Opcode field widths
    localparam int unsigned OPC_W = 16;
    localparam int unsigned DATA_W = 8;
    // Upper-bit patterns (6, 7 or 8 bits) of each decoded instruction
    localparam logic [5:0] LATCH_WRITE_HI6 = 6'h29;  // 1010 01
    localparam logic [5:0] LATCH_READ_HI6 = 6'h28;   // 1010 00
    localparam logic [7:0] TEST_SKIP_HI8 = 8'h33;    // 0011 0011
    localparam logic [7:0] XOR_LIT_HI8 = 8'hB4;      // 1011 0100
    localparam logic [6:0] XOR_FILE_HI7 = 7'h06;     // 0000 110
    // Field positions inside the opcode
    localparam int unsigned SEL_T_BIT = 9;
    localparam int unsigned DEST_D_BIT = 8;
    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] LATCH_RST = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Instruction cycle phases
    typedef enum logic [1:0]
    {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE = 2'b11
    } lwx_phase_t;

    // Decoded operation
    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_LATCH_WRITE = 3'b001,
        OP_LATCH_READ = 3'b010,
        OP_TEST_SKIP = 3'b011,
        OP_XOR_LIT = 3'b100,
        OP_XOR_FILE = 3'b101
    } lwx_op_t;
endpackage

// [lwx_dec_if.sv]
// Interface carrying the decoded instruction between decoder and executer
`timescale 1ns/100ps
interface lwx_dec_if;
    lwx_pkg::lwx_op_t op;
    logic sel_t;
    logic dest_d;
    logic [7:0] operand;

    modport dec
    (
        output op,
        output sel_t,
        output dest_d,
        output operand
    );
    modport exe
    (
        input op,
        input sel_t,
        input dest_d,
        input operand
    );
endinterface

// [lwx_decoder.sv]
// Combinational opcode decoder for the supported instructions
`timescale 1ns/100ps
module lwx_decoder
(
    // Opcode in
    input wire logic [15:0] opcode_i,
    // Decoded fields out
    lwx_dec_if.dec dec
);
    // Match upper bits; low byte is the file address or literal
    always_comb
    begin
        dec.op = lwx_pkg::OP_NONE;
        if (opcode_i[15:10] == lwx_pkg::LATCH_WRITE_HI6)
            dec.op = lwx_pkg::OP_LATCH_WRITE;
        else if (opcode_i[15:10] == lwx_pkg::LATCH_READ_HI6)
            dec.op = lwx_pkg::OP_LATCH_READ;
        else if (opcode_i[15:8] == lwx_pkg::TEST_SKIP_HI8)
            dec.op = lwx_pkg::OP_TEST_SKIP;
        else if (opcode_i[15:8] == lwx_pkg::XOR_LIT_HI8)
            dec.op = lwx_pkg::OP_XOR_LIT;
        else if (opcode_i[15:9] == lwx_pkg::XOR_FILE_HI7)
            dec.op = lwx_pkg::OP_XOR_FILE;
        dec.sel_t = opcode_i[lwx_pkg::SEL_T_BIT];
        dec.dest_d = opcode_i[lwx_pkg::DEST_D_BIT];
        dec.operand = opcode_i[7:0];
    end
endmodule

// [lwx_core.sv]
// Four-phase execute unit for latch write/read, test-skip and XOR instructions
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps

// Behaviour
// - Latch write decodes from 1010 01tx plus a file address, runs one cycle, keeps flags.
// - Latch write copies the file byte into one half of the 16-bit latch only.
// - Selector t high loads the high latch byte, t low loads the low latch byte.
// - Test-skip decodes from 0011 0011 plus an address, reads the file, keeps flags.
// - A zero test result discards the prefetched word and runs a no-operation cycle.
// - Literal XOR decodes from 1011 0100 plus an immediate and takes one cycle.
// - Literal XOR writes accumulator XOR immediate back to the accumulator, zero flag only.
// - Latch read copies the selected latch byte into a file register, latch unchanged.
module lwx_core
(
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    // Instruction in, sampled at the decode phase
    input wire logic [15:0] OPCODE_I,
    // File register read data for the address on FILE_ADDR_O
    input wire logic [7:0] FILE_RDATA_I,
    // Phase and file register access
    output logic [1:0] PHASE_O,
    output logic [7:0] FILE_ADDR_O,
    output logic FILE_WE_O,
    output logic [7:0] FILE_WDATA_O,
    // Architectural state
    output logic [7:0] ACC_O,
    output logic [15:0] LATCH_O,
    output logic ZERO_FLAG_O,
    // Pulse in the decode phase after the write phase: prefetched word is discarded
    output logic SKIP_O,
    // High for four clocks after a skip, from the no-operation cycle's read phase through the next decode phase
    output logic NOP_CYCLE_O
);
    lwx_dec_if dbus ();

    // Decoder sees the raw opcode; its result is captured at decode phase
    lwx_decoder u_dec
    (
        .opcode_i(OPCODE_I),
        .dec(dbus)
    );

    lwx_pkg::lwx_phase_t phase_q, phase_d;
    lwx_pkg::lwx_op_t op_q, op_d;
    logic sel_t_q, sel_t_d;
    logic dest_d_q, dest_d_d;
    logic [7:0] operand_q, operand_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] result_q, result_d;
    logic [7:0] acc_q, acc_d;
    logic [15:0] latch_q, latch_d;
    logic zero_q, zero_d;
    logic we_q, we_d;
    logic [7:0] wdata_q, wdata_d;
    logic skip_q, skip_d;
    logic nop_q, nop_d;
    logic nop_pend_q, nop_pend_d;

    // Phase sequencing and per-phase datapath
    always_comb
    begin
        phase_d = phase_q;
        op_d = op_q;
        sel_t_d = sel_t_q;
        dest_d_d = dest_d_q;
        operand_d = operand_q;
        rdata_d = rdata_q;
        result_d = result_q;
        acc_d = acc_q;
        latch_d = latch_q;
        zero_d = zero_q;
        we_d = 1'b0;
        wdata_d = wdata_q;
        skip_d = 1'b0;
        nop_d = nop_q;
        nop_pend_d = nop_pend_q;
        unique case (phase_q)
            lwx_pkg::PH_DECODE:
            begin
                phase_d = lwx_pkg::PH_READ;
                nop_d = nop_pend_q;
                nop_pend_d = 1'b0;
                // A discarded word is replaced by a no-operation cycle
                if (nop_pend_q)
                    op_d = lwx_pkg::OP_NONE;
                else
                    op_d = dbus.op;
                sel_t_d = dbus.sel_t;
                dest_d_d = dbus.dest_d;
                operand_d = dbus.operand;
            end
            lwx_pkg::PH_READ:
            begin
                phase_d = lwx_pkg::PH_PROCESS;
                // Operand read: file byte, latch half, or the literal itself
                unique case (op_q)
                    lwx_pkg::OP_LATCH_READ:
                        rdata_d = sel_t_q ? latch_q[15:8] : latch_q[7:0];
                    lwx_pkg::OP_XOR_LIT:
                        rdata_d = operand_q;
                    default:
                        rdata_d = FILE_RDATA_I;
                endcase
            end
            lwx_pkg::PH_PROCESS:
            begin
                phase_d = lwx_pkg::PH_WRITE;
                if (op_q == lwx_pkg::OP_XOR_LIT || op_q == lwx_pkg::OP_XOR_FILE)
                    result_d = acc_q ^ rdata_q;
                else
                    result_d = rdata_q;
            end
            lwx_pkg::PH_WRITE:
            begin
                phase_d = lwx_pkg::PH_DECODE;
                unique case (op_q)
                    lwx_pkg::OP_LATCH_WRITE:
                    begin
                        // Only the selected half changes; no flag is touched
                        if (sel_t_q)
                            latch_d[15:8] = result_q;
                        else
                            latch_d[7:0] = result_q;
                    end
                    lwx_pkg::OP_LATCH_READ:
                    begin
                        we_d = 1'b1;
                        wdata_d = result_q;
                    end
                    lwx_pkg::OP_TEST_SKIP:
                    begin
                        // Flags stay; a zero byte kills the prefetched word
                        if (result_q == lwx_pkg::ZERO_BYTE)
                        begin
                            skip_d = 1'b1;
                            nop_pend_d = 1'b1;
                        end
                    end
                    lwx_pkg::OP_XOR_LIT:
                    begin
                        acc_d = result_q;
                        zero_d = (result_q == lwx_pkg::ZERO_BYTE);
                    end
                    lwx_pkg::OP_XOR_FILE:
                    begin
                        if (dest_d_q)
                        begin
                            we_d = 1'b1;
                            wdata_d = result_q;
                        end
                        else
                            acc_d = result_q;
                        zero_d = (result_q == lwx_pkg::ZERO_BYTE);
                    end
                    default:
                    begin
                        we_d = 1'b0;
                    end
                endcase
            end
        endcase
    end

    // State registers; reset values are a design choice
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            phase_q <= lwx_pkg::PH_DECODE;
            op_q <= lwx_pkg::OP_NONE;
            sel_t_q <= 1'b0;
            dest_d_q <= 1'b0;
            operand_q <= lwx_pkg::ZERO_BYTE;
            rdata_q <= lwx_pkg::ZERO_BYTE;
            result_q <= lwx_pkg::ZERO_BYTE;
            acc_q <= lwx_pkg::ACC_RST;
            latch_q <= lwx_pkg::LATCH_RST;
            zero_q <= 1'b0;
            we_q <= 1'b0;
            wdata_q <= lwx_pkg::ZERO_BYTE;
            skip_q <= 1'b0;
            nop_q <= 1'b0;
            nop_pend_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            op_q <= op_d;
            sel_t_q <= sel_t_d;
            dest_d_q <= dest_d_d;
            operand_q <= operand_d;
            rdata_q <= rdata_d;
            result_q <= result_d;
            acc_q <= acc_d;
            latch_q <= latch_d;
            zero_q <= zero_d;
            we_q <= we_d;
            wdata_q <= wdata_d;
            skip_q <= skip_d;
            nop_q <= nop_d;
            nop_pend_q <= nop_pend_d;
        end
    end

    // Outputs straight from flip-flops; address is the latched low byte
    assign PHASE_O = phase_q;
    assign FILE_ADDR_O = operand_q;
    assign FILE_WE_O = we_q;
    assign FILE_WDATA_O = wdata_q;
    assign ACC_O = acc_q;
    assign LATCH_O = latch_q;
    assign ZERO_FLAG_O = zero_q;
    assign SKIP_O = skip_q;
    assign NOP_CYCLE_O = nop_q;
endmodule

// [lwx_core_properties.sv]
// Concurrent property checker for the latch-write, test-skip and XOR execute core
`timescale 1ns/100ps
module lwx_core_properties
(
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    // Stimulus seen by the core
    input wire logic [15:0] OPCODE_I,
    input wire logic [7:0] FILE_RDATA_I,
    // Core outputs
    input wire logic [1:0] PHASE_O,
    input wire logic [7:0] FILE_ADDR_O,
    input wire logic FILE_WE_O,
    input wire logic [7:0] FILE_WDATA_O,
    input wire logic [7:0] ACC_O,
    input wire logic [15:0] LATCH_O,
    input wire logic ZERO_FLAG_O,
    input wire logic SKIP_O,
    input wire logic NOP_CYCLE_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RESET_I);
    logic [15:0] op_q;
    logic [7:0] rd_q;
    // Results are judged in decode, except after a discarded word
    wire chk = (PHASE_O == 2'h0) && !NOP_CYCLE_O;
    // Shadow of the decoded word and the byte read in phase 1
    always_ff @(posedge REF_CLK_I)
    begin
        if (PHASE_O == 2'h0 && !RESET_I)
            op_q <= OPCODE_I;
        if (PHASE_O == 2'h1 && !RESET_I)
            rd_q <= FILE_RDATA_I;
    end
    property p_phase;
        !$past(RESET_I) |-> PHASE_O == $past(PHASE_O) + 2'h1;
    endproperty
    a_phase: assert property (p_phase) else $error("phase order broken");
    property p_addr;
        PHASE_O == 2'h1 && !$past(RESET_I) |-> FILE_ADDR_O == $past(OPCODE_I[7:0]);
    endproperty
    a_addr: assert property (p_addr) else $error("file address wrong");
    property p_xlit;
        chk && op_q[15:8] == 8'hB4 |-> ACC_O == ($past(ACC_O) ^ op_q[7:0])
            && ZERO_FLAG_O == (ACC_O == 8'h00);
    endproperty
    a_xlit: assert property (p_xlit) else $error("literal xor wrong");
    property p_xacc;
        chk && op_q[15:8] == 8'h0C |-> ACC_O == ($past(ACC_O) ^ rd_q) && !FILE_WE_O;
    endproperty
    a_xacc: assert property (p_xacc) else $error("file xor to acc wrong");
    property p_xfile;
        chk && op_q[15:8] == 8'h0D |-> FILE_WE_O && FILE_WDATA_O == (ACC_O ^ rd_q)
            && $stable(ACC_O) && ZERO_FLAG_O == (FILE_WDATA_O == 8'h00);
    endproperty
    a_xfile: assert property (p_xfile) else $error("file xor to file wrong");
    property p_lwr;
        chk && op_q[15:10] == 6'h29 |-> $stable(ZERO_FLAG_O) && LATCH_O == (op_q[9] ?
            {rd_q, $past(LATCH_O[7:0])} : {$past(LATCH_O[15:8]), rd_q});
    endproperty
    a_lwr: assert property (p_lwr) else $error("latch write wrong");
    property p_lrd;
        chk && op_q[15:10] == 6'h28 |-> FILE_WE_O && $stable(LATCH_O)
            && FILE_WDATA_O == (op_q[9] ? LATCH_O[15:8] : LATCH_O[7:0]);
    endproperty
    a_lrd: assert property (p_lrd) else $error("latch read wrong");
    property p_tst;
        chk && op_q[15:8] == 8'h33 |-> SKIP_O == (rd_q == 8'h00) && $stable(ZERO_FLAG_O);
    endproperty
    a_tst: assert property (p_tst) else $error("test skip wrong");
    property p_nop;
        SKIP_O |=> NOP_CYCLE_O [*4] ##1 !NOP_CYCLE_O;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op cycle wrong");
    // Main scenarios reached
    c_skip: cover property (SKIP_O);
    c_we: cover property (FILE_WE_O);
    c_zero: cover property ($rose(ZERO_FLAG_O));
endmodule

bind lwx_core lwx_core_properties u_props (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
    .OPCODE_I(OPCODE_I), .FILE_RDATA_I(FILE_RDATA_I), .PHASE_O(PHASE_O),
    .FILE_ADDR_O(FILE_ADDR_O), .FILE_WE_O(FILE_WE_O), .FILE_WDATA_O(FILE_WDATA_O),
    .ACC_O(ACC_O), .LATCH_O(LATCH_O), .ZERO_FLAG_O(ZERO_FLAG_O), .SKIP_O(SKIP_O),
    .NOP_CYCLE_O(NOP_CYCLE_O));

// [lwx_core_tb.sv]
// Self-checking bench for the latch-write, test-skip and XOR execute core
`timescale 1ns/100ps
module lwx_core_tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [15:0] opc = 16'h0000;
    logic [7:0] rdat = 8'h00;
    logic [1:0] phase;
    logic [7:0] addr;
    logic we;
    logic [7:0] wdat;
    logic [7:0] acc;
    logic [15:0] lat;
    logic zero;
    logic skip;
    logic nop;
    int n_fail = 0;
    int checked = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    lwx_core DUT (.REF_CLK_I(clk), .RESET_I(rst), .OPCODE_I(opc), .FILE_RDATA_I(rdat),
        .PHASE_O(phase), .FILE_ADDR_O(addr), .FILE_WE_O(we), .FILE_WDATA_O(wdat),
        .ACC_O(acc), .LATCH_O(lat), .ZERO_FLAG_O(zero), .SKIP_O(skip), .NOP_CYCLE_O(nop));
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One word: put up before decode, hold the byte through phase 1, then the follow-on
    // word goes up so a skip has something real to discard; results seen in next decode
    task automatic run(input logic [15:0] op, input logic [7:0] rd, input logic [15:0] nxt,
        input logic [7:0] e_acc, input logic [15:0] e_lat, input logic [2:0] e_f,
        input logic [7:0] e_wd);
        @(negedge clk);
        while (phase !== 2'h3)
            @(negedge clk);
        @(posedge clk);
        opc <= op;
        rdat <= rd;
        repeat (2) @(posedge clk);
        opc <= nxt;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({8'h00, acc}, {8'h00, e_acc});
        check(lat, e_lat);
        check({13'h0000, zero, we, skip}, {13'h0000, e_f});
        if (e_f[1])
            check({8'h00, wdat}, {8'h00, e_wd});
        check({8'h00, addr}, {8'h00, op[7:0]});
        // One clock on: phase 1, and the no-op cycle runs only after a skip
        @(negedge clk);
        check({13'h0000, phase, nop}, {13'h0000, 2'h1, e_f[0]});
        $display("test %h done", op);
    endtask
    // Main sequence; flags are {zero, write, skip}
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        check({2'h0, phase, acc, zero, we, skip, nop}, 16'h0000);
        check(lat, 16'h0000);
        run(16'hB4B5, 8'h00, 16'h0000, 8'hB5, 16'h0000, 3'h0, 8'h00);
        run(16'hB4AF, 8'h00, 16'h0000, 8'h1A, 16'h0000, 3'h0, 8'h00);
        run(16'hB41A, 8'h00, 16'h0000, 8'h00, 16'h0000, 3'h4, 8'h00);
        run(16'hA412, 8'hB7, 16'h0000, 8'h00, 16'h00B7, 3'h4, 8'h00);
        run(16'hA734, 8'h5C, 16'h0000, 8'h00, 16'h5CB7, 3'h4, 8'h00);
        run(16'hA240, 8'h11, 16'h0000, 8'h00, 16'h5CB7, 3'h6, 8'h5C);
        run(16'hA041, 8'h11, 16'h0000, 8'h00, 16'h5CB7, 3'h6, 8'hB7);
        run(16'hB4B5, 8'h00, 16'h0000, 8'hB5, 16'h5CB7, 3'h0, 8'h00);
        run(16'h0D21, 8'hAF, 16'h0000, 8'hB5, 16'h5CB7, 3'h2, 8'h1A);
        run(16'h0C22, 8'hB5, 16'h0000, 8'h00, 16'h5CB7, 3'h4, 8'h00);
        run(16'h3355, 8'h01, 16'hB40F, 8'h00, 16'h5CB7, 3'h4, 8'h00);
        run(16'hB400, 8'h00, 16'h0000, 8'h0F, 16'h5CB7, 3'h0, 8'h00);
        run(16'h3356, 8'h00, 16'hB4FF, 8'h0F, 16'h5CB7, 3'h1, 8'h00);
        run(16'hB400, 8'h00, 16'h0000, 8'h0F, 16'h5CB7, 3'h0, 8'h00);
        tally_and_finish();
    end
    // Watchdog: the sequence needs about 115 clocks, so 1000 is ample
    initial
    begin
        #40000;
        n_fail++;
        $display("ERROR at %0t: timeout", $time);
        tally_and_finish();
    end
endmodule
